// ### rtl/hbscw_pkg.sv
// hbscw_pkg: offsets, field positions, reset values and states of the
// host-bus slave with two control words and a shared memory window.
// assumes the host bus presents word-aligned byte addresses.
package hbscw_pkg;
    // byte offsets of the two control words from the switch base
    localparam logic [1:0] HBSCW_CW0_OFF = 2'h0;
    localparam logic [1:0] HBSCW_CW1_OFF = 2'h2;
    // widths of the host and module address spaces, the window offset and the switch base
    localparam int HBSCW_HADDR_W = 22;
    localparam int HBSCW_MADDR_W = 20;
    localparam int HBSCW_OFFS_W = 16;
    localparam int HBSCW_BASE_W = 13;
    // control word zero fields
    localparam int HBSCW_MS_LSB = 0;
    localparam int HBSCW_RUN_BIT = 4;
    localparam int HBSCW_VID_LSB = 5;
    localparam int HBSCW_WBASE_LSB = 8;
    localparam int HBSCW_PIE_BIT = 14;
    localparam int HBSCW_DOORBELL_BIT = 15;
    // control word one fields
    localparam int HBSCW_ALTREQ_BIT = 2;
    localparam int HBSCW_VEC_LSB = 3;
    localparam int HBSCW_PAGE_LSB = 9;
    localparam int HBSCW_WEN_BIT = 13;
    localparam int HBSCW_AIE_BIT = 14;
    localparam int HBSCW_HA_BIT = 15;
    // reset values of the writable fields
    localparam logic [5:0] HBSCW_WBASE_RST = 6'h00;
    localparam logic [5:0] HBSCW_VEC_RST = 6'h00;
    localparam logic [3:0] HBSCW_PAGE_RST = 4'h0;
    localparam logic HBSCW_RUN_RST = 1'b0;
    // variant code, value is arbitrary
    localparam logic [2:0] HBSCW_VARIANT_ID = 3'h5;
    // host bus cycle states
    typedef enum logic [3:0] {
        HBSCW_ST_IDLE = 4'h1,
        HBSCW_ST_MEM = 4'h2,
        HBSCW_ST_REPLY = 4'h4,
        HBSCW_ST_SKIP = 4'h8
    } hbscw_state_t;
endpackage

// ### rtl/hbscw_sync.sv
// hbscw_sync: two-flop synchroniser bank for host bus pins.
// assumes each bit is a level that holds for several clocks.
`timescale 1ns/1ps
module hbscw_sync
    import hbscw_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk_sys_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    // elaboration check: an empty bank would leave nothing to resync
    if (WIDTH < 1)
    begin : g_bad_width
        $error("hbscw_sync: WIDTH must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hbscw_sync_t;

    hbscw_sync_t s_reg;
    hbscw_sync_t s_next;

    // first stage is read only by the second stage
    always_comb
    begin
        s_next.meta = pin_i;
        s_next.stable = s_reg.meta;
    end

    // no reset: the chain flushes while the block reset is held
    always_ff @(posedge clk_sys_i)
    begin
        s_reg <= s_next;
    end

    assign sync_o = s_reg.stable;
endmodule // hbscw_sync

// ### rtl/hbscw_window.sv
// hbscw_window: memory window comparator and module address builder.
// assumes address and control come from synchronised host pins.
`timescale 1ns/1ps
module hbscw_window
    import hbscw_pkg::*;
(
    input wire logic [HBSCW_HADDR_W-1:0] addr_i,
    input wire logic io_page_i,
    input wire logic [5:0] window_base_i,
    input wire logic window_enable_i,
    input wire logic [3:0] module_page_i,
    output logic match_o,
    output logic [HBSCW_MADDR_W-1:0] mem_addr_o
);
    // comparator is gated by the enable so a shared base stays silent
    always_comb
    begin
        match_o = window_enable_i && !io_page_i &&
            (addr_i[HBSCW_HADDR_W-1:HBSCW_OFFS_W] == window_base_i);
    end

    // page on top, host offset below; module ROM is never reachable
    always_comb
    begin
        mem_addr_o = {module_page_i, addr_i[HBSCW_OFFS_W-1:0]};
    end
endmodule // hbscw_window

// ### rtl/hbscw_top.sv
// hbscw_top: host-bus slave with two control words, a 64-Kbyte window
// into module memory and two vectored interrupts.
// assumes the host holds cycle, address and data steady until reply,
// and the module side (memory, main processor) runs on clk_sys_i.
`timescale 1ns/1ps
module hbscw_top
    import hbscw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic bus_init_i,
    input wire logic bus_cycle_i,
    input wire logic bus_write_i,
    input wire logic bus_iack_i,
    input wire logic bus_io_page_i,
    input wire logic [HBSCW_HADDR_W-1:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic [HBSCW_BASE_W-1:0] switch_selected_base_i,
    input wire logic diag_rom_fitted_i,
    output logic [15:0] bus_rdata_o,
    output logic bus_rdata_oe_o,
    output logic bus_rply_o,
    output logic bus_irq_o,
    input wire logic [3:0] module_state_i,
    input wire logic alert_set_i,
    input wire logic doorbell_ack_i,
    input wire logic timer_i,
    output logic host_doorbell_o,
    output logic mp_reset_n_o,
    output logic refresh_en_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [HBSCW_MADDR_W-1:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i
);
    localparam int SYNC_W = HBSCW_HADDR_W + 16 + HBSCW_BASE_W + 6;

    typedef struct packed {
        hbscw_state_t st;
        logic run;
        logic strap_pend;
        logic doorbell;
        logic pie;
        logic [5:0] wbase;
        logic ha;
        logic aie;
        logic wen;
        logic [3:0] page;
        logic [5:0] vec;
        logic [15:0] rdata;
        logic rdata_oe;
        logic rply;
        logic mem_req;
        logic mem_we;
        logic [HBSCW_MADDR_W-1:0] mem_addr;
        logic [15:0] mem_wdata;
    } hbscw_core_t;

    hbscw_core_t r_reg;
    hbscw_core_t r_next;

    logic [SYNC_W-1:0] sync_s;
    logic init_s;
    logic cyc_s;
    logic write_s;
    logic iack_s;
    logic io_s;
    logic rom_s;
    logic [HBSCW_HADDR_W-1:0] addr_s;
    logic [15:0] wdata_s;
    logic [HBSCW_BASE_W-1:0] base_s;
    logic grst;
    logic csr_hit;
    logic hit_w0;
    logic hit_w1;
    logic win_hit;
    logic [HBSCW_MADDR_W-1:0] win_addr;
    logic alert_irq;
    logic timer_irq;
    logic [15:0] cw0_rd;
    logic [15:0] cw1_rd;
    logic [15:0] vector;

    // every host bus pin, strap and base switches included, passes two flops before use; nrst_i and module-side inputs do not
    hbscw_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .pin_i({bus_init_i, bus_cycle_i, bus_write_i, bus_iack_i,
            bus_io_page_i, diag_rom_fitted_i, bus_addr_i, bus_wdata_i,
            switch_selected_base_i}),
        .sync_o(sync_s)
    );

    assign {init_s, cyc_s, write_s, iack_s, io_s, rom_s, addr_s, wdata_s,
        base_s} = sync_s;

    hbscw_window u_window (
        .addr_i(addr_s),
        .io_page_i(io_s),
        .window_base_i(r_reg.wbase),
        .window_enable_i(r_reg.wen),
        .module_page_i(r_reg.page),
        .match_o(win_hit),
        .mem_addr_o(win_addr)
    );

    // global reset from bus init or the board reset
    assign grst = !nrst_i || init_s;

    // control words: base aligned to four, word one at base plus two
    always_comb
    begin
        csr_hit = io_s && (addr_s[HBSCW_BASE_W-1:2] ==
            base_s[HBSCW_BASE_W-1:2]);
        hit_w0 = csr_hit && (addr_s[1:0] == HBSCW_CW0_OFF);
        hit_w1 = csr_hit && (addr_s[1:0] == HBSCW_CW1_OFF);
    end

    // interrupt sources; alert wins the vector when both pend
    always_comb
    begin
        alert_irq = r_reg.ha && r_reg.aie;
        timer_irq = r_reg.pie && timer_i;
        vector = '0;
        vector[HBSCW_VEC_LSB +: 6] = r_reg.vec;
        vector[HBSCW_ALTREQ_BIT] = !alert_irq && timer_irq;
    end

    // read images; alternate bit reads zero outside a vector cycle
    always_comb
    begin
        cw0_rd = '0;
        cw0_rd[HBSCW_MS_LSB +: 4] = module_state_i;
        cw0_rd[HBSCW_RUN_BIT] = r_reg.run;
        cw0_rd[HBSCW_VID_LSB +: 3] = HBSCW_VARIANT_ID;
        cw0_rd[HBSCW_WBASE_LSB +: 6] = r_reg.wbase;
        cw0_rd[HBSCW_PIE_BIT] = r_reg.pie;
        cw0_rd[HBSCW_DOORBELL_BIT] = r_reg.doorbell;
        cw1_rd = '0;
        cw1_rd[HBSCW_VEC_LSB +: 6] = r_reg.vec;
        cw1_rd[HBSCW_PAGE_LSB +: 4] = r_reg.page;
        cw1_rd[HBSCW_WEN_BIT] = r_reg.wen;
        cw1_rd[HBSCW_AIE_BIT] = r_reg.aie;
        cw1_rd[HBSCW_HA_BIT] = r_reg.ha;
    end

    // next state: strap, module clears, bus cycle, then module sets
    always_comb
    begin
        r_next = r_reg;
        // strap load one cycle after release; a host write then wins
        if (r_reg.strap_pend)
        begin
            r_next.run = rom_s;
            r_next.strap_pend = 1'b0;
        end
        if (doorbell_ack_i)
            r_next.doorbell = 1'b0;
        unique case (r_reg.st)
            HBSCW_ST_IDLE:
            begin
                if (cyc_s)
                begin
                    if (iack_s)
                    begin
                        r_next.rdata = vector;
                        r_next.rdata_oe = 1'b1;
                        r_next.rply = 1'b1;
                        r_next.st = HBSCW_ST_REPLY;
                    end
                    else if (hit_w0 || hit_w1)
                    begin
                        if (write_s && hit_w0)
                        begin
                            // state and variant bits are not stored
                            r_next.run = wdata_s[HBSCW_RUN_BIT];
                            r_next.wbase = wdata_s[HBSCW_WBASE_LSB +: 6];
                            r_next.pie = wdata_s[HBSCW_PIE_BIT];
                            if (wdata_s[HBSCW_DOORBELL_BIT])
                                r_next.doorbell = 1'b1;
                        end
                        else if (write_s)
                        begin
                            r_next.vec = wdata_s[HBSCW_VEC_LSB +: 6];
                            r_next.page = wdata_s[HBSCW_PAGE_LSB +: 4];
                            r_next.wen = wdata_s[HBSCW_WEN_BIT];
                            r_next.aie = wdata_s[HBSCW_AIE_BIT];
                            if (wdata_s[HBSCW_HA_BIT])
                                r_next.ha = 1'b0;
                        end
                        else
                        begin
                            r_next.rdata = hit_w0 ? cw0_rd : cw1_rd;
                            r_next.rdata_oe = 1'b1;
                        end
                        r_next.rply = 1'b1;
                        r_next.st = HBSCW_ST_REPLY;
                    end
                    else if (win_hit)
                    begin
                        r_next.mem_req = 1'b1;
                        r_next.mem_we = write_s;
                        r_next.mem_addr = win_addr;
                        r_next.mem_wdata = wdata_s;
                        r_next.st = HBSCW_ST_MEM;
                    end
                    else
                        r_next.st = HBSCW_ST_SKIP;
                end
            end
            HBSCW_ST_MEM:
            begin
                // memory is reachable whether or not the processor runs
                if (mem_ack_i)
                begin
                    r_next.mem_req = 1'b0;
                    if (!r_reg.mem_we)
                    begin
                        r_next.rdata = mem_rdata_i;
                        r_next.rdata_oe = 1'b1;
                    end
                    r_next.rply = 1'b1;
                    r_next.st = HBSCW_ST_REPLY;
                end
            end
            HBSCW_ST_REPLY:
            begin
                // reply stands until the host ends the cycle
                if (!cyc_s)
                begin
                    r_next.rply = 1'b0;
                    r_next.rdata_oe = 1'b0;
                    r_next.st = HBSCW_ST_IDLE;
                end
            end
            HBSCW_ST_SKIP:
            begin
                // not ours: stay silent, the host times out
                if (!cyc_s)
                    r_next.st = HBSCW_ST_IDLE;
            end
            default:
                r_next.st = HBSCW_ST_IDLE;
        endcase
        // module event after host clear: the set wins
        if (alert_set_i)
            r_next.ha = 1'b1;
    end

    // synchronous global reset; strap is caught after release
    always_ff @(posedge clk_sys_i)
    begin
        if (grst)
        begin
            r_reg <= '0;
            r_reg.st <= HBSCW_ST_IDLE;
            r_reg.run <= HBSCW_RUN_RST;
            r_reg.wbase <= HBSCW_WBASE_RST;
            r_reg.vec <= HBSCW_VEC_RST;
            r_reg.page <= HBSCW_PAGE_RST;
            r_reg.strap_pend <= 1'b1;
        end
        else
            r_reg <= r_next;
    end

    // processor held while stopped; refresh only while it runs
    assign mp_reset_n_o = r_reg.run && !grst;
    assign refresh_en_o = r_reg.run && !grst;
    assign bus_irq_o = alert_irq || timer_irq;
    assign bus_rdata_o = r_reg.rdata;
    assign bus_rdata_oe_o = r_reg.rdata_oe;
    assign bus_rply_o = r_reg.rply;
    assign host_doorbell_o = r_reg.doorbell;
    assign mem_req_o = r_reg.mem_req;
    assign mem_we_o = r_reg.mem_we;
    assign mem_addr_o = r_reg.mem_addr;
    assign mem_wdata_o = r_reg.mem_wdata;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (grst);

    sequence idle_start_s;
        r_reg.st == HBSCW_ST_IDLE && cyc_s && !iack_s;
    endsequence
    sequence rd0_s;
        idle_start_s ##0 hit_w0 && !write_s;
    endsequence
    sequence rd1_s;
        idle_start_s ##0 hit_w1 && !write_s;
    endsequence
    sequence wr0_s;
        idle_start_s ##0 hit_w0 && write_s;
    endsequence
    sequence wr1_s;
        idle_start_s ##0 hit_w1 && write_s;
    endsequence
    sequence iack_s_seq;
        r_reg.st == HBSCW_ST_IDLE && cyc_s && iack_s;
    endsequence

    run_readback_a: assert property (
        rd0_s |=> bus_rply_o && bus_rdata_oe_o &&
            bus_rdata_o[HBSCW_RUN_BIT] == $past(r_reg.run))
        else $error("run bit read does not match run state");
    strap_load_a: assert property (
        r_reg.strap_pend && !(r_reg.st == HBSCW_ST_IDLE && cyc_s &&
            hit_w0 && write_s) |=> r_reg.run == $past(rom_s))
        else $error("run bit did not take ROM strap");
    run_stop_a: assert property (
        wr0_s ##0 !wdata_s[HBSCW_RUN_BIT] |=> !mp_reset_n_o
            && !refresh_en_o)
        else $error("processor not stopped by run bit write");
    run_start_a: assert property (
        wr0_s ##0 wdata_s[HBSCW_RUN_BIT] |=> mp_reset_n_o
            && refresh_en_o)
        else $error("processor not started by run bit write");
    variant_fixed_a: assert property (
        rd0_s |=> bus_rdata_o[HBSCW_VID_LSB +: 3] == HBSCW_VARIANT_ID)
        else $error("variant code read wrong");
    window_map_a: assert property (
        idle_start_s ##0 !io_s && r_reg.wen &&
            addr_s[21:16] == r_reg.wbase |=> mem_req_o &&
            mem_addr_o == {$past(r_reg.page), $past(addr_s[15:0])})
        else $error("window access not mapped to module memory");
    window_off_a: assert property (
        idle_start_s ##0 !r_reg.wen && !csr_hit |=> !mem_req_o ##1
            !mem_req_o)
        else $error("memory answered while window disabled");
    doorbell_set_a: assert property (
        wr0_s ##0 wdata_s[HBSCW_DOORBELL_BIT] |=> host_doorbell_o)
        else $error("doorbell not set by host write");
    doorbell_hold_a: assert property (
        host_doorbell_o && !doorbell_ack_i |=> host_doorbell_o)
        else $error("doorbell dropped without module ack");
    alert_clear_a: assert property (
        wr1_s ##0 wdata_s[HBSCW_HA_BIT] && !alert_set_i |=> !r_reg.ha)
        else $error("host alert not cleared by write of one");
    alert_set_a: assert property (
        alert_set_i |=> r_reg.ha)
        else $error("host alert not set by module event");
    alert_irq_a: assert property (
        wr1_s ##0 wdata_s[HBSCW_AIE_BIT] && !wdata_s[HBSCW_HA_BIT] &&
            r_reg.ha |=> bus_irq_o)
        else $error("alert enable on pending flag gave no request");
    low_bits_a: assert property (
        rd1_s |=> bus_rdata_o[2:0] == 3'h0 &&
            bus_rdata_o[HBSCW_VEC_LSB +: 6] == $past(r_reg.vec))
        else $error("word one low bits not zero");
    vector_alert_a: assert property (
        iack_s_seq ##0 alert_irq |=>
            bus_rdata_o[8:0] == {$past(r_reg.vec), 3'h0})
        else $error("alert vector wrong");
    vector_timer_a: assert property (
        iack_s_seq ##0 !alert_irq && timer_irq |=>
            bus_rdata_o[8:0] == {$past(r_reg.vec), 3'h4})
        else $error("timer vector wrong");
endmodule // hbscw_top

// ### verif/hbscw_host_model.sv
// hbscw_host_model: behavioural host bus master for hbscw_top.
// assumes the slave answers with a reply level held until cycle drops.
`timescale 1ns/1ps
module hbscw_host_model
    import hbscw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rply_i,
    input wire logic [15:0] rdata_i,
    output logic init_o,
    output logic cyc_o,
    output logic wr_o,
    output logic iack_o,
    output logic io_o,
    output logic [HBSCW_HADDR_W-1:0] addr_o,
    output logic [15:0] wdata_o
);
    // bus idle at time zero
    initial
    begin
        {init_o, cyc_o, wr_o, iack_o, io_o} = 5'h00;
        addr_o = '0;
        wdata_o = 16'h0000;
    end
    // one cycle; qualifiers stay put until the reply is sampled high
    task automatic xfer(input logic w, input logic ia, input logic io,
        input logic [HBSCW_HADDR_W-1:0] a, input logic [15:0] d,
        output logic [15:0] rd, output logic ok);
        ok = 1'b0;
        rd = 16'h0000;
        @(posedge clk_sys_i);
        #2;
        {wr_o, iack_o, io_o, addr_o, wdata_o} = {w, ia, io, a, d};
        cyc_o = 1'b1;
        // refused cycles never reply, so the wait is bounded
        for (int n = 0; n < 40 && ok !== 1'b1; n++)
        begin
            @(posedge clk_sys_i);
            if (rply_i === 1'b1)
            begin
                ok = 1'b1;
                rd = rdata_i;
            end
        end
        #2;
        cyc_o = 1'b0;
        // released lines must not keep showing the last value
        addr_o = ~a;
        wdata_o = ~d;
        for (int n = 0; n < 10 && rply_i !== 1'b0; n++)
            @(posedge clk_sys_i);
        // hand back off the edge so callers never drive inputs on it
        #2;
    endtask
    // global reset through the bus init line
    task automatic pulse_init(input int cycles);
        @(posedge clk_sys_i);
        #2;
        init_o = 1'b1;
        repeat (cycles) @(posedge clk_sys_i);
        #2;
        init_o = 1'b0;
    endtask
endmodule // hbscw_host_model

// ### verif/testbench.sv
// testbench: self-checking bench for hbscw_top with a register model,
// a host master model and a module memory responder.
// assumes memory answers each request with a single ack pulse.
`timescale 1ns/1ps
module testbench
    import hbscw_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic nrst_i, bus_init, bus_cyc, bus_wr, bus_iack, bus_io, rom, ok;
    logic alert_set, db_ack, timer, mem_ack, rdata_oe, rply, irq;
    logic db_o, mp_rst_n, refresh, mem_req, mem_we;
    logic [HBSCW_HADDR_W-1:0] bus_addr, a0;
    logic [15:0] bus_wdata, rdata, mem_wdata, mem_rdata, rd, given;
    logic [HBSCW_MADDR_W-1:0] mem_addr;
    logic [HBSCW_BASE_W-1:0] sw_base;
    logic [3:0] ms;
    logic [31:0] seed = 32'hD6A6DBED;
    logic [31:0] r;
    logic [36:0] m_exp;
    logic [36:0] q[$];
    int n_errors, n_checks, cyc_cnt, mem_wait;
    int m_wbase, m_pie, m_door, m_run, m_page, m_vec, m_wen, m_aie, m_ha;

    hbscw_host_model host (.clk_sys_i(clk_sys_i), .rply_i(rply),
        .rdata_i(rdata), .init_o(bus_init), .cyc_o(bus_cyc), .wr_o(bus_wr),
        .iack_o(bus_iack), .io_o(bus_io), .addr_o(bus_addr),
        .wdata_o(bus_wdata));
    hbscw_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .bus_init_i(bus_init), .bus_cycle_i(bus_cyc), .bus_write_i(bus_wr),
        .bus_iack_i(bus_iack), .bus_io_page_i(bus_io), .bus_addr_i(bus_addr),
        .bus_wdata_i(bus_wdata), .switch_selected_base_i(sw_base),
        .diag_rom_fitted_i(rom), .bus_rdata_o(rdata),
        .bus_rdata_oe_o(rdata_oe), .bus_rply_o(rply), .bus_irq_o(irq),
        .module_state_i(ms), .alert_set_i(alert_set),
        .doorbell_ack_i(db_ack), .timer_i(timer), .host_doorbell_o(db_o),
        .mp_reset_n_o(mp_rst_n), .refresh_en_o(refresh),
        .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .mem_ack_i(mem_ack));

    // 20 MHz system clock
    always #25 clk_sys_i = ~clk_sys_i;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reset values of the model; run follows the rom strap
    task automatic model_init();
        {m_wbase, m_pie, m_door, m_page, m_vec, m_wen, m_aie, m_ha} = '0;
        m_run = rom;
    endtask
    task automatic do_reset();
        @(posedge clk_sys_i);
        #2;
        nrst_i = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        #2;
        nrst_i = 1'b1;
        model_init();
        repeat (4) @(posedge clk_sys_i);
    endtask
    function automatic logic [15:0] exp_w(input int w);
        if (w == 0)
            return {1'(m_door), 1'(m_pie), 6'(m_wbase), HBSCW_VARIANT_ID,
                1'(m_run), ms};
        return {1'(m_ha), 1'(m_aie), 1'(m_wen), 4'(m_page), 6'(m_vec),
            3'b000};
    endfunction
    task automatic rd_reg(input int w);
        host.xfer(1'b0, 1'b0, 1'b1, a0 + 22'(2 * w), 16'h0000, rd, ok);
        check("control read", {ok, rd}, {1'b1, exp_w(w)});
    endtask
    task automatic wr_reg(input int w, input logic [15:0] d);
        host.xfer(1'b1, 1'b0, 1'b1, a0 + 22'(2 * w), d, rd, ok);
        check("control write", ok, 1);
        if (w == 0)
            {m_door, m_pie, m_wbase, m_run} = {m_door | d[15], 31'h0, d[14],
                26'h0, d[13:8], 31'h0, d[4]};
        else
            {m_ha, m_aie, m_wen, m_page, m_vec} = {m_ha & ~32'(d[15]),
                31'h0, d[14], 31'h0, d[13], 28'h0, d[12:9], 26'h0, d[8:3]};
    endtask
    task automatic vec_rd(input logic b);
        host.xfer(1'b0, 1'b1, 1'b0, '0, 16'h0000, rd, ok);
        check("vector", {ok, rd[8:0]}, {1'b1, 6'(m_vec), b, 2'b00});
    endtask
    task automatic pulse(input logic door);
        @(posedge clk_sys_i);
        #2;
        {db_ack, alert_set} = {door, ~door};
        @(posedge clk_sys_i);
        #2;
        {db_ack, alert_set} = 2'b00;
        @(posedge clk_sys_i);
        #2;
    endtask
    task automatic win(input logic w, input logic [15:0] off);
        q.push_back({w, r[31:16], 4'(m_page), off});
        host.xfer(w, 1'b0, 1'b0, {6'(m_wbase), off}, r[31:16], rd, ok);
        check("window reply", ok, 1);
        if (!w)
            check("window read", rd, given);
    endtask

    // memory answers after a short random wait; idle data is scrambled
    always @(posedge clk_sys_i)
    begin
        #2;
        if (mem_ack)
            {mem_ack, mem_rdata} = {1'b0, ~mem_rdata};
        else if (mem_req === 1'b1 && mem_wait > 0)
            mem_wait--;
        else if (mem_req === 1'b1)
        begin
            m_exp = (q.size() > 0) ? q.pop_front() : '1;
            check("mem addr", mem_addr, m_exp[19:0]);
            check("mem we", mem_we, m_exp[36]);
            if (m_exp[36])
                check("mem wdata", mem_wdata, m_exp[35:20]);
            mem_rdata = 16'(rnd());
            given = mem_rdata;
            mem_ack = 1'b1;
            mem_wait = rnd() % 3;
        end
    end
    // data drivers must stand with every reply of a read or vector cycle
    always @(posedge clk_sys_i)
        if (rply === 1'b1)
            check("rdata oe", rdata_oe, !bus_wr);
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    initial
    begin
        {nrst_i, rom, alert_set, db_ack, timer, mem_ack} = 6'h00;
        {n_errors, n_checks, cyc_cnt, mem_wait} = '0;
        mem_rdata = 16'hA5C3;
        ms = 4'h0;
        r = rnd();
        sw_base = {r[12:2], 2'b00};
        a0 = {9'h1FF, sw_base};
        do_reset();
        rd_reg(0);
        check("held", {mp_rst_n, refresh}, 0);
        ms = r[19:16];
        // base before window enable; read-only bits written inverted
        wr_reg(0, {2'b11, r[29:24], ~HBSCW_VARIANT_ID, 1'b1, ~ms});
        rd_reg(0);
        check("run", {mp_rst_n, refresh, db_o}, 7);
        wr_reg(0, {2'b01, 6'(m_wbase), 3'b000, 1'b1, 4'h0});
        rd_reg(0);
        pulse(1'b1);
        m_door = 0;
        check("doorbell ack", db_o, 0);
        r = rnd();
        wr_reg(1, {3'b011, r[3:0], r[9:4], 3'b000});
        rd_reg(1);
        // window traffic in both directions at random offsets
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            win(r[0], {r[15:1], 1'b0});
        end
        host.xfer(1'b0, 1'b0, 1'b0, {6'(m_wbase) ^ 6'h01, 16'h0010},
            16'h0000, rd, ok);
        check("foreign base", ok, 0);
        host.xfer(1'b0, 1'b0, 1'b1, a0 + 22'h1, 16'h0000, rd, ok);
        check("odd offset", ok, 0);
        wr_reg(1, {3'b010, 4'(m_page), 6'(m_vec), 3'b000});
        host.xfer(1'b0, 1'b0, 1'b0, {6'(m_wbase), 16'h0010}, 16'h0000, rd, ok);
        check("window off", ok, 0);
        pulse(1'b0);
        m_ha = 1;
        check("alert irq", irq, 1);
        rd_reg(1);
        vec_rd(1'b0);
        wr_reg(1, {3'b000, 4'(m_page), 6'(m_vec), 3'b000});
        check("alert masked", irq, 0);
        wr_reg(1, {3'b010, 4'(m_page), 6'(m_vec), 3'b000});
        check("late enable", irq, 1);
        // host clears the alert before it looks at module state
        wr_reg(1, {3'b110, 4'(m_page), 6'(m_vec), 3'b000});
        check("alert cleared", irq, 0);
        rd_reg(0);
        timer = 1'b1;
        #1;
        check("timer irq", irq, 1);
        vec_rd(1'b1);
        wr_reg(0, {2'b00, 6'(m_wbase), 3'b000, 1'b0, 4'h0});
        check("stopped", {mp_rst_n, refresh, irq}, 0);
        // restart needs the stop held for at least one microsecond
        repeat (20) @(posedge clk_sys_i);
        wr_reg(0, {2'b01, 6'(m_wbase), 3'b000, 1'b1, 4'h0});
        check("restarted", {mp_rst_n, refresh}, 3);
        host.pulse_init(4);
        model_init();
        repeat (4) @(posedge clk_sys_i);
        rd_reg(0);
        rd_reg(1);
        check("init held", {mp_rst_n, irq}, 0);
        timer = 1'b0;
        rom = 1'b1;
        do_reset();
        rd_reg(0);
        check("rom run", mp_rst_n, 1);
        wr_reg(0, 16'h0000);
        rd_reg(0);
        check("rom stop", mp_rst_n, 0);
        close_out();
    end
endmodule // testbench
